//--- verilog/ipwdt_top.sv
// Purpose: Watchdog timer behind an index/data port pair
// Assumes: Host bus strobes are one-cycle and synchronous to sys_clk_i
// Notes:   Tick prescaler is a parameter so that simulation can shorten it
`timescale 1ns/1ps
// How it works
// - Index port write picks a register; data port reads or writes it.
// - Two consecutive unlock key writes to the index port enter configuration mode.
// - Writing function number 08 to index 07 selects the watchdog registers.
// - Function enable bit 0 turns the watchdog on; off after reset.
// - Mode bit 3 picks seconds (0, default) or minutes (1).
// - Mode bit 4 makes ticks 1000 times faster.
// - Count 0 stops the timer; 01 to FF sets units to timeout.
// - Count expiring without reload asserts the timeout output.
// - Any write to the count register restarts the countdown.
// - Control bit 6 lets keyboard activity reload the timer.
// - Writing control bit 5 forces an immediate timeout, bit self-clears.
// - Control bit 4 reads one after a timeout.
// - Control bit 7 lets mouse activity reload the timer.
// - Lock key write on the index port leaves configuration mode.
module ipwdt_top #(
  parameter int MS_CYCLES = ipwdt_pkg::IPWDT_MS_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic       kbd_act_i,
  input  wire logic       mouse_act_i,
  output logic      [7:0] io_rdata_o,
  output logic            io_rvalid_o,
  output logic            timeout_o
);
  import ipwdt_pkg::*;

  typedef enum logic [2:0] {
    IPWDT_LOCKED = 3'b001,
    IPWDT_HALF   = 3'b010,
    IPWDT_OPEN   = 3'b100
  } ipwdt_lock_e;

  ipwdt_lock_e lock_ff;
  logic [7:0]  index_ff;
  logic [7:0]  fsel_ff;
  logic        fen_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  count_ff;
  logic        kbd_en_ff;
  logic        mouse_en_ff;
  logic        stat_ff;
  logic [31:0] pre_ff;
  logic [15:0] unit_ff;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic        tout_ff;

  logic addr_wr;
  logic data_wr;
  logic data_rd;
  logic wdt_sel;
  logic wr_fen;
  logic wr_mode;
  logic wr_cnt;
  logic wr_ctrl;
  logic force_to;
  logic reload;
  logic ms_tick;
  logic unit_tick;
  logic running;
  logic expire;
  logic [15:0] unit_lim;

  // Port decode; data writes only count once configuration is open
  assign addr_wr  = io_wr_i && (io_addr_i == IPWDT_ADDR_PORT);
  assign data_wr  = io_wr_i && (io_addr_i == IPWDT_DATA_PORT) && (lock_ff == IPWDT_OPEN);
  assign data_rd  = io_rd_i && (io_addr_i == IPWDT_DATA_PORT);
  assign wdt_sel  = (fsel_ff == IPWDT_FUNC_WDT);
  assign wr_fen   = data_wr && wdt_sel && (index_ff == IPWDT_IDX_FEN);
  assign wr_mode  = data_wr && wdt_sel && (index_ff == IPWDT_IDX_MODE);
  assign wr_cnt   = data_wr && wdt_sel && (index_ff == IPWDT_IDX_COUNT);
  assign wr_ctrl  = data_wr && wdt_sel && (index_ff == IPWDT_IDX_CTRL);
  assign force_to = wr_ctrl && io_wdata_i[IPWDT_FORCE_BIT];
  assign reload   = (kbd_en_ff && kbd_act_i) || (mouse_en_ff && mouse_act_i);
  assign running  = fen_ff && (count_ff != 8'h00);

  // Unit length in ms ticks: 1000 per second, 60000 per minute; fast mode divides by 1000
  always_comb begin
    unit_lim = 16'(IPWDT_SEC_MS);
    if (mode_ff[IPWDT_MIN_BIT]) begin
      unit_lim = 16'(IPWDT_SEC_MS * IPWDT_MIN_SEC);
    end
    if (mode_ff[IPWDT_FAST_BIT]) begin
      unit_lim = mode_ff[IPWDT_MIN_BIT] ? 16'(IPWDT_MIN_SEC) : 16'd1;
    end
  end

  assign ms_tick   = (pre_ff == 32'(MS_CYCLES - 1));
  assign unit_tick = ms_tick && (unit_ff == unit_lim - 16'd1);
  assign expire    = running && unit_tick && (count_ff == 8'h01);

  // Unlock needs two key writes back to back; any other index write breaks it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_ff <= IPWDT_LOCKED;
    end else if (addr_wr) begin
      unique case (lock_ff)
        IPWDT_LOCKED: lock_ff <= (io_wdata_i == IPWDT_KEY_UNLOCK) ? IPWDT_HALF : IPWDT_LOCKED;
        IPWDT_HALF:   lock_ff <= (io_wdata_i == IPWDT_KEY_UNLOCK) ? IPWDT_OPEN : IPWDT_LOCKED;
        IPWDT_OPEN:   lock_ff <= (io_wdata_i == IPWDT_KEY_LOCK) ? IPWDT_LOCKED : IPWDT_OPEN;
        default:      lock_ff <= IPWDT_LOCKED;
      endcase
    end
  end

  // Index and function select
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      index_ff <= IPWDT_RST_BYTE;
      fsel_ff  <= IPWDT_RST_BYTE;
    end else begin
      if (addr_wr && (lock_ff == IPWDT_OPEN)) begin
        index_ff <= io_wdata_i;
      end
      if (data_wr && (index_ff == IPWDT_IDX_FSEL)) begin
        fsel_ff <= io_wdata_i;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fen_ff      <= 1'b0;
      mode_ff     <= IPWDT_RST_BYTE;
      kbd_en_ff   <= 1'b0;
      mouse_en_ff <= 1'b0;
    end else begin
      if (wr_fen) begin
        fen_ff <= io_wdata_i[IPWDT_FEN_BIT];
      end
      if (wr_mode) begin
        mode_ff <= io_wdata_i;
      end
      if (wr_ctrl) begin
        kbd_en_ff   <= io_wdata_i[IPWDT_KBD_BIT];
        mouse_en_ff <= io_wdata_i[IPWDT_MOUSE_BIT];
      end
    end
  end

  // Prescaler chain; restarted on reload so a fresh unit is whole
  // Trade-off: a free-running phase would let a timeout come up to one unit early
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_ff  <= 32'h0;
      unit_ff <= 16'h0;
    end else if (!running || wr_cnt || reload) begin
      pre_ff  <= 32'h0;
      unit_ff <= 16'h0;
    end else if (ms_tick) begin
      pre_ff  <= 32'h0;
      unit_ff <= unit_tick ? 16'h0 : unit_ff + 16'd1;
    end else begin
      pre_ff <= pre_ff + 32'd1;
    end
  end

  // Countdown: a software write reloads, an activity reload restores the last load
  logic [7:0] load_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_ff <= IPWDT_RST_BYTE;
      load_ff  <= IPWDT_RST_BYTE;
    end else if (wr_cnt) begin
      count_ff <= io_wdata_i;
      load_ff  <= io_wdata_i;
    end else if (reload && running) begin
      count_ff <= load_ff;
    end else if (running && unit_tick) begin
      count_ff <= count_ff - 8'd1;
    end
  end

  // Timeout output and sticky status; a fresh event wins over the clearing write
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tout_ff <= 1'b0;
      stat_ff <= 1'b0;
    end else begin
      if (expire || force_to) begin
        tout_ff <= 1'b1;
        stat_ff <= 1'b1;
      end else if (wr_ctrl && !io_wdata_i[IPWDT_STAT_BIT]) begin
        stat_ff <= 1'b0;
        tout_ff <= 1'b0;
      end else if (wr_cnt) begin
        tout_ff <= 1'b0;
      end
    end
  end

  // Read data; locked or unmapped reads return ff as a floating bus would
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff  <= IPWDT_RST_BYTE;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= data_rd;
      if (data_rd) begin
        rdata_ff <= 8'hff;
        if (lock_ff == IPWDT_OPEN) begin
          if (index_ff == IPWDT_IDX_FSEL) begin
            rdata_ff <= fsel_ff;
          end else if (wdt_sel) begin
            unique case (index_ff)
              IPWDT_IDX_FEN:   rdata_ff <= {7'h00, fen_ff};
              IPWDT_IDX_MODE:  rdata_ff <= mode_ff;
              IPWDT_IDX_COUNT: rdata_ff <= count_ff;
              IPWDT_IDX_CTRL:  rdata_ff <= {mouse_en_ff, kbd_en_ff, 1'b0, stat_ff, 4'h0};
              default:         rdata_ff <= 8'hff;
            endcase
          end
        end
      end
    end
  end

  assign io_rdata_o  = rdata_ff;
  assign io_rvalid_o = rvalid_ff;
  assign timeout_o   = tout_ff;

  // Unlock keys, one step at a time; idle cycles between the two keys are legal
  sequence s_first_key;
    lock_ff == IPWDT_LOCKED && addr_wr && io_wdata_i == IPWDT_KEY_UNLOCK;
  endsequence
  sequence s_second_key;
    lock_ff == IPWDT_HALF && addr_wr && io_wdata_i == IPWDT_KEY_UNLOCK;
  endsequence
  a_first_key: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_first_key |=> lock_ff == IPWDT_HALF)
    else $error("first unlock key not taken");
  a_unlock_seq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_second_key |=> lock_ff == IPWDT_OPEN)
    else $error("two unlock keys did not open");
  a_unlock_break: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    lock_ff == IPWDT_HALF && addr_wr && io_wdata_i != IPWDT_KEY_UNLOCK
      |=> lock_ff == IPWDT_LOCKED)
    else $error("broken key pair still unlocked");
  a_lock_key: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    lock_ff == IPWDT_OPEN && addr_wr && io_wdata_i == IPWDT_KEY_LOCK |=> lock_ff == IPWDT_LOCKED)
    else $error("lock key did not lock");
  // Index, function select, enable, mode and activity enables hold unless configuration is open
  a_locked_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    lock_ff != IPWDT_OPEN |=> $stable(mode_ff) && $stable(fen_ff) && $stable(fsel_ff)
      && $stable(index_ff) && $stable(kbd_en_ff) && $stable(mouse_en_ff))
    else $error("register changed while locked");
  // An expiry in the same cycle as the write still wins the timeout flag
  a_count_load: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_cnt |=> count_ff == $past(io_wdata_i) && (!tout_ff || $past(expire)))
    else $error("count write did not reload");
  a_force_out: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    force_to |=> timeout_o && stat_ff)
    else $error("forced timeout missing");
  a_expire_out: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    expire && !wr_cnt && !reload |=> timeout_o && count_ff == 8'h00)
    else $error("expiry gave no timeout");
  a_stop_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    count_ff == 8'h00 && !wr_cnt |=> count_ff == 8'h00)
    else $error("stopped timer counted");
  a_dec_tick: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && unit_tick && !wr_cnt && !reload |=> count_ff == $past(count_ff) - 8'd1)
    else $error("count did not step");
  a_kbd_reload: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && !wr_cnt && kbd_act_i && kbd_en_ff |=> count_ff == load_ff)
    else $error("keyboard reload missed");
  a_mouse_reload: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && !wr_cnt && mouse_act_i && mouse_en_ff |=> count_ff == load_ff)
    else $error("mouse reload missed");
  // Count only moves on a tick, a write or a reload
  a_count_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    running && !wr_cnt && !reload && !unit_tick |=> $stable(count_ff))
    else $error("count moved between ticks");
  a_off_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !fen_ff && !wr_cnt |=> $stable(count_ff))
    else $error("disabled timer counted");
  a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    data_rd && lock_ff == IPWDT_OPEN && wdt_sel && index_ff == IPWDT_IDX_CTRL
      |=> io_rvalid_o && io_rdata_o[IPWDT_STAT_BIT] == $past(stat_ff))
    else $error("status bit misread");

  // Read handshake, locked read data and sticky flags
  a_rvalid_pulse: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    1'b1 |=> io_rvalid_o == $past(data_rd))
    else $error("read valid not one cycle after strobe");
  a_locked_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    data_rd && lock_ff != IPWDT_OPEN |=> io_rdata_o == 8'hff)
    else $error("locked read returned data");
  a_status_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    stat_ff && !wr_ctrl |=> stat_ff)
    else $error("status cleared without a write");
  a_tout_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    timeout_o && !wr_ctrl && !wr_cnt |=> timeout_o)
    else $error("timeout dropped without a write");
endmodule

//--- verilog/ipwdt_pkg.sv
// Purpose: Constants for the indexed-port watchdog timer
// Assumes: 8-bit port bus, 100 MHz system clock
// Notes:   Port addresses, register indexes, field positions and timing counts
package ipwdt_pkg;
  localparam logic [7:0] IPWDT_ADDR_PORT  = 8'h2e;
  localparam logic [7:0] IPWDT_DATA_PORT  = 8'h2f;
  localparam logic [7:0] IPWDT_KEY_UNLOCK = 8'h87;
  localparam logic [7:0] IPWDT_KEY_LOCK   = 8'haa;
  localparam logic [7:0] IPWDT_IDX_FSEL   = 8'h07;
  localparam logic [7:0] IPWDT_FUNC_WDT   = 8'h08;
  localparam logic [7:0] IPWDT_IDX_FEN    = 8'h30;
  localparam logic [7:0] IPWDT_IDX_MODE   = 8'hf5;
  localparam logic [7:0] IPWDT_IDX_COUNT  = 8'hf6;
  localparam logic [7:0] IPWDT_IDX_CTRL   = 8'hf7;
  localparam int         IPWDT_FEN_BIT    = 0;
  localparam int         IPWDT_MIN_BIT    = 3;
  localparam int         IPWDT_FAST_BIT   = 4;
  localparam int         IPWDT_STAT_BIT   = 4;
  localparam int         IPWDT_FORCE_BIT  = 5;
  localparam int         IPWDT_KBD_BIT    = 6;
  localparam int         IPWDT_MOUSE_BIT  = 7;
  localparam logic [7:0] IPWDT_RST_BYTE   = 8'h00;
  localparam int         IPWDT_CLK_MHZ    = 100;
  localparam int         IPWDT_MS_US      = 1000;
  localparam int         IPWDT_MS_CYC     = IPWDT_MS_US * IPWDT_CLK_MHZ;
  localparam int         IPWDT_SEC_MS     = 1000;
  localparam int         IPWDT_MIN_SEC    = 60;
  localparam int         IPWDT_FAST_DIV   = 1000;
endpackage

//--- verification/ipwdt_top_tb.sv
// Purpose: Self-checking bench for the indexed-port watchdog timer
// Assumes: Millisecond prescaler shortened to MS cycles; strobes one cycle
// Notes:   Whole minutes are only timed in fast form to keep the run short
`timescale 1ns/1ps
module ipwdt_top_tb;
  import ipwdt_pkg::*;
  localparam int MS = 4;
  logic       sys_clk_i, rstn_i, io_wr_i, io_rd_i, kbd_act_i, mouse_act_i;
  logic [7:0] io_addr_i, io_wdata_i, io_rdata_o;
  logic       io_rvalid_o, timeout_o;
  int         fails, n_tests, seed, n, c, s;
  logic [7:0] md [3] = '{8'h10, 8'h18, 8'h00};

  ipwdt_top #(.MS_CYCLES(MS)) dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .kbd_act_i(kbd_act_i), .mouse_act_i(mouse_act_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .timeout_o(timeout_o));

  // Free-running system clock
  always #5 sys_clk_i = ~sys_clk_i;

  // Cycles per count unit, from the mode byte
  function automatic int unit(input logic [7:0] m);
    unit = MS * (m[IPWDT_MIN_BIT] ? IPWDT_MIN_SEC : 1) * (m[IPWDT_FAST_BIT] ? 1 : IPWDT_SEC_MS);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One write strobe; a clock edge always separates two strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    io_addr_i  = a;
    io_wdata_i = d;
    io_wr_i    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    io_wr_i = 1'b0;
  endtask

  task automatic rg(input logic [7:0] idx, input logic [7:0] d);
    wr(IPWDT_ADDR_PORT, idx);
    wr(IPWDT_DATA_PORT, d);
  endtask

  // Select index, then read data port; answer is due one cycle after the strobe
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    wr(IPWDT_ADDR_PORT, idx);
    @(posedge sys_clk_i);
    #1;
    io_addr_i = IPWDT_DATA_PORT;
    io_rd_i   = 1'b1;
    @(posedge sys_clk_i);
    #1;
    io_rd_i = 1'b0;
    chk({7'h00, io_rvalid_o}, 8'h01);
    chk(io_rdata_o, exp);
  endtask

  // Bounded wait for timeout; a count write restarts the prescaler, so lo and hi may meet
  task automatic wt(input int lo, input int hi);
    for (c = 0; c <= hi && timeout_o !== 1'b1; c++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk({7'h00, c >= lo && c <= hi}, 8'h01);
    if (timeout_o !== 1'b1) begin
      complete_run();
    end
  endtask

  task automatic quiet(input int k);
    repeat (k) begin
      @(posedge sys_clk_i);
      #1;
      chk({7'h00, timeout_o}, 8'h00);
    end
  endtask

  // Hang guard
  initial begin
    #900000;
    fails++;
    complete_run();
  end

  initial begin
    {sys_clk_i, rstn_i, io_wr_i, io_rd_i, kbd_act_i, mouse_act_i} = '0;
    {io_addr_i, io_wdata_i} = '0;
    {fails, n_tests} = '0;
    seed = 50519;
    repeat (8) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    rg(IPWDT_IDX_FEN, 8'h01);
    wr(IPWDT_ADDR_PORT, IPWDT_KEY_UNLOCK);
    wr(IPWDT_ADDR_PORT, IPWDT_IDX_COUNT);
    wr(IPWDT_ADDR_PORT, IPWDT_KEY_UNLOCK);
    rd(IPWDT_IDX_FEN, 8'hff);
    wr(IPWDT_ADDR_PORT, IPWDT_KEY_UNLOCK);
    wr(IPWDT_ADDR_PORT, IPWDT_KEY_UNLOCK);
    rd(IPWDT_IDX_MODE, 8'hff);
    rg(IPWDT_IDX_FSEL, IPWDT_FUNC_WDT);
    rd(IPWDT_IDX_FEN, 8'h00);
    rd(IPWDT_IDX_MODE, 8'h00);
    rd(IPWDT_IDX_CTRL, 8'h00);
    rg(IPWDT_IDX_FEN, 8'h01);
    rd(IPWDT_IDX_FEN, 8'h01);
    // Fast seconds, fast minutes and plain seconds each time out after count units; status then reads set
    foreach (md[i]) begin
      n = (i == 0) ? 1 + $unsigned($random(seed)) % 8 : 2;
      rg(IPWDT_IDX_MODE, md[i]);
      rg(IPWDT_IDX_COUNT, n[7:0]);
      wt(n * unit(md[i]), n * unit(md[i]));
      rd(IPWDT_IDX_CTRL, 8'h10);
      rg(IPWDT_IDX_CTRL, 8'h00);
    end
    rg(IPWDT_IDX_MODE, 8'h10);
    quiet(60);
    rg(IPWDT_IDX_COUNT, 8'h05);
    repeat (12) @(posedge sys_clk_i);
    rg(IPWDT_IDX_COUNT, 8'h05);
    wt(5 * unit(8'h10), 5 * unit(8'h10));
    rg(IPWDT_IDX_CTRL, 8'h00);
    // Activity pulses reload only the enabled source
    for (s = 0; s < 3; s++) begin
      rg(IPWDT_IDX_CTRL, {s == 2, s == 1, 6'h00});
      rg(IPWDT_IDX_COUNT, 8'h02);
      for (c = 0; c < 40; c++) begin
        @(posedge sys_clk_i);
        #1;
        // Phase 1 of 3 so both activity lines are low again when the loop ends
        kbd_act_i   = (s != 2) && (c % 3 == 1);
        mouse_act_i = (s != 1) && (c % 3 == 1);
      end
      chk({7'h00, timeout_o}, {7'h00, s == 0});
      rg(IPWDT_IDX_CTRL, 8'h00);
    end
    rg(IPWDT_IDX_COUNT, 8'h00);
    rg(IPWDT_IDX_CTRL, 8'h20);
    wt(0, 0);
    rd(IPWDT_IDX_CTRL, 8'h10);
    rg(IPWDT_IDX_CTRL, 8'h00);
    rg(IPWDT_IDX_COUNT, 8'h02);
    rg(IPWDT_IDX_FEN, 8'h00);
    quiet(40);
    wr(IPWDT_ADDR_PORT, IPWDT_KEY_LOCK);
    rd(IPWDT_IDX_FEN, 8'hff);
    complete_run();
  end
endmodule
